// File: pkg/codec_regs_params.svh
// constants for the per-channel codec control register bank
// assumes command bytes arrive msb first, read/write flag in bit 0
//
// How it works
// - command bit 0: zero writes, one reads
// - status bit shows channel active
// - clock-fail bit set while unsynchronised
// - clock-fail readable with no channel enabled
// - five line pin directions, cleared at reset
// - coding bit and a-law/mu-law bit
// - select bit picks default or programmed coefficients
// - masked real-time bit never pulls interrupt low
// - interrupt mask resets to all ones
// - cutoff bits; balance filter off during receive cutoff
// - highpass bypass bit and extra receive loss
// - transmit interrupt armed only while bit set
// - slot loopback and full digital loopback bits
// - test tone present while tone bit set
// - revision byte read regardless of channel enables
// - transmit gain: two bytes, one plus product
// - transmit gain word default at reset
// - receive gain: two bytes, product only
// - receive gain word default at reset
// - channel commands touch only enabled channels
`ifndef CODEC_REGS_PARAMS_SVH
`define CODEC_REGS_PARAMS_SVH

// ==========================================================
// command opcodes, bits 7..1
`define OP_DIR 7'h2a
`define OP_OPF 7'h30
`define OP_MASK 7'h36
`define OP_OPC 7'h38
`define OP_REV 7'h39
`define OP_GX 7'h40
`define OP_GR 7'h41
`define CMD_RW_BIT 0
`define CMD_DIR_WR {`OP_DIR, 1'b0}
`define CMD_DIR_RD {`OP_DIR, 1'b1}
`define CMD_OPC_WR {`OP_OPC, 1'b0}
`define CMD_GX_WR {`OP_GX, 1'b0}
`define CMD_REV_RD {`OP_REV, 1'b1}

// ==========================================================
// field positions
`define STAT_ACTIVE 6
`define STAT_CLOCK_SYNC_LOST 5
`define OPF_LINEAR 7
`define OPF_MULAW 6
`define OPF_EGR 5
`define OPF_EGX 4
`define OPC_CTP 7
`define OPC_CRP 6
`define OPC_HPF 5
`define OPC_RG 4
`define OPC_ATI 3
`define OPC_ILB 2
`define OPC_FDL 1
`define OPC_TON 0

// ==========================================================
// reset values
`define DIR_RST 5'h00
`define OPF_RST 8'h00
`define MASK_RST 8'hff
`define OPC_RST 8'h00
`define GX_RST 16'ha9f0
`define GR_RST 16'h23a1

`endif

// File: pkg/codec_regs_pkg.sv
// types shared by the codec register bank modules
// assumes codec_regs_params.svh supplies the constants
package codec_regs_pkg;

  typedef enum logic [1:0] {ST_CMD, ST_WR, ST_RD} core_state_e;

  typedef struct packed {
    logic [4:0] dir;
    logic [7:0] opf;
    logic [7:0] opc;
    logic [15:0] gx;
    logic [15:0] gr;
    logic [15:0] gx_eff;
    logic [15:0] gr_eff;
  } chan_regs_s;

endpackage

// File: pkg/byte_link_if.sv
// byte link between the serial shifter and the register core
// assumes both ends run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface byte_link_if;
  logic [7:0] rx_byte;
  logic rx_stb;
  logic frame;
  logic [7:0] tx_byte;
  logic tx_load;
  modport shifter (output rx_byte, rx_stb, frame, input tx_byte, tx_load);
  modport core (input rx_byte, rx_stb, frame, output tx_byte, tx_load);
endinterface
`default_nettype wire

// File: design/pin_sync.sv
// two-stage synchroniser for pin inputs
// assumes a free running clock; reset value given by parameter
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_s;
  sync_s st;
  sync_s next_st;

  always_comb
  begin
    next_st.meta = d;
    next_st.sync = st.meta;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= {INIT, INIT};
    else
      st <= next_st;
  end

  assign q = st.sync;
endmodule
`default_nettype wire

// File: design/host_byte_shifter.sv
// serial byte shifter for the host command port
// assumes synchronised pins; data shifts in msb first on rising dclk, out on falling dclk
`timescale 1ns/1ns
`default_nettype none
module host_byte_shifter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dclk,
  input wire logic din,
  input wire logic cs_n,
  output logic dout,
  output logic dout_oe,
  byte_link_if.shifter lnk
);
  typedef struct packed {
    logic dclk_d;
    logic [7:0] sh_in;
    logic [2:0] cnt;
    logic [7:0] sh_out;
    logic dout;
    logic oe;
    logic [7:0] rx_byte;
    logic rx_stb;
  } shift_s;
  shift_s st;
  shift_s next_st;

  always_comb
  begin
    next_st = st;
    next_st.dclk_d = dclk;
    next_st.rx_stb = 1'b0;
    if (cs_n)
    begin
      next_st.cnt = 3'h0;
      next_st.oe = 1'b0;
    end
    else if (dclk && !st.dclk_d)
    begin
      next_st.sh_in = {st.sh_in[6:0], din};
      next_st.cnt = st.cnt + 3'h1;
      if (st.cnt == 3'h7)
      begin
        next_st.rx_byte = {st.sh_in[6:0], din};
        next_st.rx_stb = 1'b1;
      end
    end
    // no shift on the fall that opens a byte, so a fresh load survives
    else if (!dclk && st.dclk_d && st.cnt != 3'h0)
    begin
      next_st.dout = st.sh_out[7];
      next_st.sh_out = {st.sh_out[6:0], 1'b0};
    end
    if (lnk.tx_load && !cs_n)
    begin
      next_st.dout = lnk.tx_byte[7];
      next_st.sh_out = {lnk.tx_byte[6:0], 1'b0};
      next_st.oe = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      // dclk idles high, so no false rise after reset
      st.dclk_d <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign dout = st.dout;
  assign dout_oe = st.oe;
  assign lnk.rx_byte = st.rx_byte;
  assign lnk.rx_stb = st.rx_stb;
  assign lnk.frame = !cs_n;
endmodule
`default_nettype wire

// File: design/codec_chan_regs.sv
// per-channel control and status registers of a four-channel codec
// assumes serial host pins from outside, status inputs on CLK
`include "codec_regs_params.svh"
`timescale 1ns/1ns
`default_nettype none
module codec_chan_regs #(
  parameter int NCHAN = 4,
  // arbitrary value, not a real revision
  parameter logic [7:0] SILICON_REV = 8'h5a
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // host command port pins
  input wire logic DCLK,
  input wire logic DIN,
  input wire logic CS_N,
  output logic DOUT,
  output logic DOUT_OE,
  // device state
  input wire logic [NCHAN-1:0] CHAN_ENABLE,
  input wire logic [NCHAN-1:0] CHAN_ACTIVE,
  input wire logic CLOCK_SYNC_LOST,
  input wire logic [2*NCHAN-1:0] RT_DATA,
  input wire logic RT_INT_CLEAR,
  // line pins and coding
  output logic [5*NCHAN-1:0] LINE_IO_DIR,
  output logic [NCHAN-1:0] CODE_LINEAR,
  output logic [NCHAN-1:0] MU_LAW,
  output logic [6*NCHAN-1:0] FILT_PROG_SEL,
  // path options
  output logic [NCHAN-1:0] TX_CUT,
  output logic [NCHAN-1:0] RX_CUT,
  output logic [NCHAN-1:0] BAL_OFF,
  output logic [NCHAN-1:0] HPF_BYPASS,
  output logic [NCHAN-1:0] RX_LOSS,
  output logic [NCHAN-1:0] TX_IRQ_ARM,
  output logic [NCHAN-1:0] SLOT_LOOP,
  output logic [NCHAN-1:0] FULL_LOOP,
  output logic [NCHAN-1:0] TONE_ON,
  // gain coefficients in use
  output logic [16*NCHAN-1:0] TX_GAIN_COEF,
  output logic [16*NCHAN-1:0] RX_GAIN_COEF,
  // interrupt
  output logic INT_N
);
  import codec_regs_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    core_state_e state;
    logic [7:0] cmd;
    logic idx;
    logic [7:0] lo_hold;
    logic [2*NCHAN-1:0] mask;
    logic [2*NCHAN-1:0] rt_prev;
    logic int_n;
    logic [7:0] tx_byte;
    logic tx_load;
    chan_regs_s [NCHAN-1:0] ch;
  } core_s;

  core_s st;
  core_s next_st;
  logic [2:0] pins;
  byte_link_if lnk();

  // ==========================================================
  // serial side
  pin_sync #(
    .W(3),
    .INIT(3'h6)
  ) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d({CS_N, DCLK, DIN}),
    .q(pins)
  );

  host_byte_shifter u_shift (
    .clk(CLK),
    .rst_n(RST_N),
    .dclk(pins[1]),
    .din(pins[0]),
    .cs_n(pins[2]),
    .dout(DOUT),
    .dout_oe(DOUT_OE),
    .lnk(lnk)
  );

  // ==========================================================
  // decode helpers
  function automatic logic known(input logic [7:0] c);
    logic k;
    k = 1'b0;
    case (c[7:1])
      `OP_DIR, `OP_OPF, `OP_MASK, `OP_OPC, `OP_GX, `OP_GR:
        k = 1'b1;
      `OP_REV:
        k = c[`CMD_RW_BIT];
      default:
        k = 1'b0;
    endcase
    return k;
  endfunction

  function automatic logic paired(input logic [7:0] c);
    return c[7:1] == `OP_GX || c[7:1] == `OP_GR;
  endfunction

  // per-channel fields are read from the lowest enabled channel; mask and revision reads are not
  function automatic logic [7:0] rd_byte(input logic [7:0] c, input logic hi);
    logic [7:0] r;
    int s;
    logic any;
    r = 8'h00;
    s = 0;
    any = 1'b0;
    for (int i = NCHAN - 1; i >= 0; i--)
    begin
      if (CHAN_ENABLE[i])
      begin
        s = i;
        any = 1'b1;
      end
    end
    case (c[7:1])
      `OP_DIR:
      begin
        r[`STAT_CLOCK_SYNC_LOST] = CLOCK_SYNC_LOST;
        if (any)
        begin
          r[`STAT_ACTIVE] = CHAN_ACTIVE[s];
          r[4:0] = st.ch[s].dir;
        end
      end
      `OP_OPF:
        r = any ? st.ch[s].opf : 8'h00;
      `OP_MASK:
        r = st.mask;
      `OP_OPC:
        r = any ? st.ch[s].opc : 8'h00;
      `OP_REV:
        r = SILICON_REV;
      `OP_GX:
        r = !any ? 8'h00 : hi ? st.ch[s].gx[7:0] : st.ch[s].gx[15:8];
      `OP_GR:
        r = !any ? 8'h00 : hi ? st.ch[s].gr[7:0] : st.ch[s].gr[15:8];
      default:
        r = 8'h00;
    endcase
    return r;
  endfunction

  // ==========================================================
  // next state
  always_comb
  begin
    next_st = st;
    next_st.tx_load = 1'b0;
    next_st.rt_prev = RT_DATA;
    // a change in the clearing cycle keeps the line low
    if (|((RT_DATA ^ st.rt_prev) & ~st.mask))
      next_st.int_n = 1'b0;
    else if (RT_INT_CLEAR)
      next_st.int_n = 1'b1;
    for (int i = 0; i < NCHAN; i++)
    begin
      next_st.ch[i].gx_eff = st.ch[i].opf[`OPF_EGX] ? st.ch[i].gx : `GX_RST;
      next_st.ch[i].gr_eff = st.ch[i].opf[`OPF_EGR] ? st.ch[i].gr : `GR_RST;
    end
    if (!lnk.frame)
    begin
      next_st.state = ST_CMD;
      next_st.idx = 1'b0;
    end
    else if (lnk.rx_stb)
    begin
      case (st.state)
        ST_CMD:
        begin
          next_st.cmd = lnk.rx_byte;
          next_st.idx = 1'b0;
          // unknown opcodes are dropped; the next byte is a command
          if (known(lnk.rx_byte))
          begin
            if (lnk.rx_byte[`CMD_RW_BIT])
            begin
              next_st.state = ST_RD;
              next_st.tx_byte = rd_byte(lnk.rx_byte, 1'b0);
              next_st.tx_load = 1'b1;
            end
            else
              next_st.state = ST_WR;
          end
        end
        ST_WR:
        begin
          if (paired(st.cmd) && !st.idx)
          begin
            next_st.lo_hold = lnk.rx_byte;
            next_st.idx = 1'b1;
          end
          else
          begin
            next_st.state = ST_CMD;
            if (st.cmd[7:1] == `OP_MASK)
              next_st.mask = lnk.rx_byte;
            for (int i = 0; i < NCHAN; i++)
            begin
              if (CHAN_ENABLE[i])
              begin
                case (st.cmd[7:1])
                  `OP_DIR:
                    next_st.ch[i].dir = lnk.rx_byte[4:0];
                  `OP_OPF:
                    next_st.ch[i].opf = lnk.rx_byte;
                  `OP_OPC:
                    next_st.ch[i].opc = lnk.rx_byte;
                  `OP_GX:
                    next_st.ch[i].gx = {st.lo_hold, lnk.rx_byte};
                  `OP_GR:
                    next_st.ch[i].gr = {st.lo_hold, lnk.rx_byte};
                  default:
                    ;
                endcase
              end
            end
          end
        end
        ST_RD:
        begin
          if (paired(st.cmd) && !st.idx)
          begin
            next_st.idx = 1'b1;
            next_st.tx_byte = rd_byte(st.cmd, 1'b1);
            next_st.tx_load = 1'b1;
          end
          else
            next_st.state = ST_CMD;
        end
        default:
          next_st.state = ST_CMD;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st <= '0;
      st.state <= ST_CMD;
      st.mask <= `MASK_RST;
      st.int_n <= 1'b1;
      for (int i = 0; i < NCHAN; i++)
      begin
        st.ch[i].dir <= `DIR_RST;
        st.ch[i].opf <= `OPF_RST;
        st.ch[i].opc <= `OPC_RST;
        st.ch[i].gx <= `GX_RST;
        st.ch[i].gr <= `GR_RST;
        st.ch[i].gx_eff <= `GX_RST;
        st.ch[i].gr_eff <= `GR_RST;
      end
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // outputs, all straight from the state
  assign lnk.tx_byte = st.tx_byte;
  assign lnk.tx_load = st.tx_load;
  assign INT_N = st.int_n;

  genvar g;
  generate
    for (g = 0; g < NCHAN; g++)
    begin : g_ch
      assign LINE_IO_DIR[5*g +: 5] = st.ch[g].dir;
      assign CODE_LINEAR[g] = st.ch[g].opf[`OPF_LINEAR];
      assign MU_LAW[g] = st.ch[g].opf[`OPF_MULAW];
      assign FILT_PROG_SEL[6*g +: 6] = st.ch[g].opf[5:0];
      assign TX_CUT[g] = st.ch[g].opc[`OPC_CTP];
      assign RX_CUT[g] = st.ch[g].opc[`OPC_CRP];
      // balance filter follows receive cutoff directly
      assign BAL_OFF[g] = st.ch[g].opc[`OPC_CRP];
      assign HPF_BYPASS[g] = st.ch[g].opc[`OPC_HPF];
      assign RX_LOSS[g] = st.ch[g].opc[`OPC_RG];
      assign TX_IRQ_ARM[g] = st.ch[g].opc[`OPC_ATI];
      assign SLOT_LOOP[g] = st.ch[g].opc[`OPC_ILB];
      assign FULL_LOOP[g] = st.ch[g].opc[`OPC_FDL];
      assign TONE_ON[g] = st.ch[g].opc[`OPC_TON];
      assign TX_GAIN_COEF[16*g +: 16] = st.ch[g].gx_eff;
      assign RX_GAIN_COEF[16*g +: 16] = st.ch[g].gr_eff;
    end
  endgenerate

  // ==========================================================
  // checks
  a_masked_no_int: assert property (@(posedge CLK) disable iff (!RST_N)
    (st.int_n && !RT_INT_CLEAR && !(|((RT_DATA ^ st.rt_prev) & ~st.mask))) |=> INT_N)
    else $error("interrupt fell without unmasked change");

  a_unmasked_int_low: assert property (@(posedge CLK) disable iff (!RST_N)
    (|((RT_DATA ^ st.rt_prev) & ~st.mask)) |=> !INT_N)
    else $error("unmasked change did not pull interrupt low");

  a_mask_reset_ones: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(RST_N) |-> st.mask == `MASK_RST)
    else $error("mask not all ones after reset");

  a_dir_write_lands: assert property (@(posedge CLK) disable iff (!RST_N)
    (st.state == ST_WR && lnk.frame && lnk.rx_stb && st.cmd == `CMD_DIR_WR
     && CHAN_ENABLE[0]) |=> LINE_IO_DIR[4:0] == $past(lnk.rx_byte[4:0]))
    else $error("direction write not applied");

  a_disabled_chan_kept: assert property (@(posedge CLK) disable iff (!RST_N)
    (st.state == ST_WR && st.cmd == `CMD_OPC_WR && !CHAN_ENABLE[0])
    |=> $stable(st.ch[0].opc))
    else $error("disabled channel was written");

  a_gain_first_byte: assert property (@(posedge CLK) disable iff (!RST_N)
    (st.state == ST_WR && lnk.rx_stb && st.cmd == `CMD_GX_WR && !st.idx)
    |=> $stable(st.ch[0].gx))
    else $error("gain latched before final byte");

  a_gain_default_sel: assert property (@(posedge CLK) disable iff (!RST_N)
    !st.ch[0].opf[`OPF_EGX] |=> TX_GAIN_COEF[15:0] == `GX_RST)
    else $error("default transmit gain not used");

  a_clock_sync_lost_readback: assert property (@(posedge CLK) disable iff (!RST_N)
    (st.state == ST_CMD && lnk.frame && lnk.rx_stb && lnk.rx_byte == `CMD_DIR_RD)
    |=> lnk.tx_load && lnk.tx_byte[`STAT_CLOCK_SYNC_LOST] == $past(CLOCK_SYNC_LOST))
    else $error("clock fail bit not returned");

  a_rev_readback: assert property (@(posedge CLK) disable iff (!RST_N)
    (st.state == ST_CMD && lnk.frame && lnk.rx_stb && lnk.rx_byte == `CMD_REV_RD)
    |=> lnk.tx_load && lnk.tx_byte == SILICON_REV)
    else $error("revision byte wrong");
endmodule
`default_nettype wire

// File: tb/host_port_model.sv
// host side of the serial command port: frames, command and data bytes
// assumes the device samples DIN on rising DCLK and shifts DOUT on falling DCLK
`timescale 1ns/1ns
`default_nettype none
module host_port_model #(
  parameter int HALF = 10
) (
  // clock
  input wire logic clk,
  // device serial answer
  input wire logic dout,
  input wire logic dout_oe,
  // host serial drive
  output var logic dclk,
  output var logic din,
  output var logic cs_n
);
  // ==========================================
  // idle: clock stands high, frame closed
  initial
  begin
    dclk = 1'b1;
    din = 1'b0;
    cs_n = 1'b1;
  end

  // ==========================================
  // one byte, msb first; half period well above the 8 clk minimum
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      @(negedge clk);
      dclk = 1'b0;
      din = tx[i];
      repeat (HALF) @(negedge clk);
      // a released line reads inverted, so it never passes for data
      rx[i] = dout_oe ? dout : ~dout;
      dclk = 1'b1;
      repeat (HALF - 1) @(negedge clk);
    end
  endtask

  // ==========================================
  // command then n data bytes, high byte first; abort drops the frame early
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int n,
                      input bit abort, output logic [15:0] rdat);
    logic [7:0] b;
    rdat = 'x;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    xbyte(cmd, b);
    for (int k = n - 1; k >= 0; k--)
    begin
      xbyte(cmd[0] ? ~wd[8*k +: 8] : wd[8*k +: 8], b);
      rdat[8*k +: 8] = b;
      if (abort)
        break;
    end
    repeat (HALF) @(negedge clk);
    cs_n = 1'b1;
    din = ~din;
    repeat (HALF) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// File: tb/tb_codec_chan_regs.sv
// self-checking bench for the codec channel register bank
// assumes the host model drives the serial pins; status inputs set here
`timescale 1ns/1ns
`default_nettype none
`include "codec_regs_params.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_codec_chan_regs;
  // arbitrary value, not a real revision
  localparam logic [7:0] REV = 8'h3c;
  logic clk, rst_n, dclk, din, cs_n, dout, dout_oe, sync_lost, rt_clear, int_n;
  logic [3:0] chan_enable, chan_active, code_lin, mu_law, tx_cut, rx_cut, bal_off;
  logic [3:0] hpf_byp, rx_loss, tx_arm, slot_loop, full_loop, tone_on;
  logic [7:0] rt_data, v;
  logic [19:0] line_dir;
  logic [23:0] filt_sel;
  logic [63:0] tx_coef, rx_coef;
  logic [15:0] rd;
  int n_mismatch = 0;
  int cmp_count = 0;

  // ==========================================
  // device and host
  codec_chan_regs #(.NCHAN(4), .SILICON_REV(REV)) dut (.CLK(clk), .RST_N(rst_n),
    .DCLK(dclk), .DIN(din), .CS_N(cs_n), .DOUT(dout), .DOUT_OE(dout_oe),
    .CHAN_ENABLE(chan_enable), .CHAN_ACTIVE(chan_active), .CLOCK_SYNC_LOST(sync_lost),
    .RT_DATA(rt_data), .RT_INT_CLEAR(rt_clear), .LINE_IO_DIR(line_dir),
    .CODE_LINEAR(code_lin), .MU_LAW(mu_law), .FILT_PROG_SEL(filt_sel), .TX_CUT(tx_cut),
    .RX_CUT(rx_cut), .BAL_OFF(bal_off), .HPF_BYPASS(hpf_byp), .RX_LOSS(rx_loss),
    .TX_IRQ_ARM(tx_arm), .SLOT_LOOP(slot_loop), .FULL_LOOP(full_loop), .TONE_ON(tone_on),
    .TX_GAIN_COEF(tx_coef), .RX_GAIN_COEF(rx_coef), .INT_N(int_n));
  host_port_model #(.HALF(10)) host (.clk(clk), .dout(dout), .dout_oe(dout_oe),
    .dclk(dclk), .din(din), .cs_n(cs_n));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================
  // access tasks and closing
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n);
    host.xfer(cmd, d, n, 1'b0, rd);
  endtask

  task automatic rdreg(input logic [7:0] cmd, input int n);
    host.xfer(cmd, 16'h0000, n, 1'b0, rd);
  endtask

  task automatic test_done;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================
  // watchdog, well beyond the ~10k cycles the tests need
  initial
  begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    $display("mismatch watchdog expected done seen hang");
    test_done();
  end

  // ==========================================
  // tests
  initial
  begin
    rst_n = 1'b0;
    chan_enable = 4'b0001;
    chan_active = 4'h0;
    sync_lost = 1'b0;
    rt_data = 8'h00;
    rt_clear = 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    `CHK("dir", 20'h00000, line_dir)
    `CHK("txg", {4{16'ha9f0}}, tx_coef)
    `CHK("rxg", {4{16'h23a1}}, rx_coef)
    `CHK("int", 1'b1, int_n)
    rdreg({`OP_MASK, 1'b1}, 1);
    `CHK("mask", 8'hff, rd[7:0])
    rdreg({`OP_OPF, 1'b1}, 1);
    `CHK("opf", 8'h00, rd[7:0])
    $display("test reset done");

    // status bits written as zero, two channels enabled
    chan_enable = 4'b0101;
    wr(`CMD_DIR_WR, 16'h001f, 1);
    `CHK("dir", 20'h07c1f, line_dir)
    chan_active = 4'b0001;
    sync_lost = 1'b1;
    rdreg(`CMD_DIR_RD, 1);
    `CHK("stat", 7'h7f, rd[6:0])
    chan_active = 4'b0000;
    sync_lost = 1'b0;
    rdreg(`CMD_DIR_RD, 1);
    `CHK("stat", 7'h1f, rd[6:0])
    chan_enable = 4'b0000;
    sync_lost = 1'b1;
    rdreg(`CMD_DIR_RD, 1);
    `CHK("clock_sync_lost", 7'h20, rd[6:0])
    $display("test status done");

    chan_enable = 4'b0001;
    wr({`OP_OPF, 1'b0}, 16'h00c5, 1);
    `CHK("lin", 4'h1, code_lin)
    `CHK("mu", 4'h1, mu_law)
    `CHK("fsel", 24'h000005, filt_sel)
    wr(`CMD_GX_WR, 16'h1234, 2);
    `CHK("txg", {4{16'ha9f0}}, tx_coef)
    wr({`OP_OPF, 1'b0}, 16'h0030, 1);
    `CHK("txg", {{3{16'ha9f0}}, 16'h1234}, tx_coef)
    `CHK("rxg", {4{16'h23a1}}, rx_coef)
    wr({`OP_GR, 1'b0}, 16'h5678, 2);
    `CHK("rxg", {{3{16'h23a1}}, 16'h5678}, rx_coef)
    host.xfer(`CMD_GX_WR, 16'hffff, 2, 1'b1, rd);
    `CHK("txg", {{3{16'ha9f0}}, 16'h1234}, tx_coef)
    rdreg({`OP_GX, 1'b1}, 2);
    `CHK("gxrd", 16'h1234, rd)
    rdreg({`OP_GR, 1'b1}, 2);
    `CHK("grrd", 16'h5678, rd)
    $display("test gains done");

    // one option bit at a time on channel 2 only
    chan_enable = 4'b0010;
    for (int i = 0; i < 8; i++)
    begin
      v = 8'h01 << i;
      wr(`CMD_OPC_WR, {8'h00, v}, 1);
      `CHK("opc", v, {tx_cut[1], rx_cut[1], hpf_byp[1], rx_loss[1], tx_arm[1], slot_loop[1], full_loop[1], tone_on[1]})
      `CHK("bal", v[6], bal_off[1])
      `CHK("ch1", 1'b0, |{tx_cut[0], rx_cut[0], tx_arm[0], tone_on[0]})
    end
    rdreg({`OP_OPC, 1'b1}, 1);
    `CHK("opcrd", 8'h80, rd[7:0])
    chan_enable = 4'b0000;
    rdreg(`CMD_REV_RD, 1);
    `CHK("rev", REV, rd[7:0])
    $display("test options done");

    // mask write does not need any channel enabled
    wr({`OP_MASK, 1'b0}, 16'h00fe, 1);
    rt_data[1] = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("int", 1'b1, int_n)
    rt_data[0] = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("int", 1'b0, int_n)
    rt_clear = 1'b1;
    @(negedge clk);
    rt_clear = 1'b0;
    @(negedge clk);
    `CHK("int", 1'b1, int_n)
    // a change in the clearing cycle wins over the clear
    rt_data[0] = 1'b0;
    rt_clear = 1'b1;
    @(negedge clk);
    rt_clear = 1'b0;
    @(negedge clk);
    `CHK("int", 1'b0, int_n)
    rdreg({`OP_MASK, 1'b1}, 1);
    `CHK("mask", 8'hfe, rd[7:0])
    $display("test interrupt done");

    // hardware reset in mid-run brings every default back
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    `CHK("int", 1'b1, int_n)
    `CHK("dir", 20'h00000, line_dir)
    `CHK("txg", {4{16'ha9f0}}, tx_coef)
    `CHK("rxg", {4{16'h23a1}}, rx_coef)
    rdreg({`OP_MASK, 1'b1}, 1);
    `CHK("mask", 8'hff, rd[7:0])
    $display("test second reset done");
    test_done();
  end
endmodule
`default_nettype wire
